/* rtl/crsv_pkg.sv */
// package: register indices, port addresses, field positions and state layout
package crsv_pkg;
  localparam logic [15:0] IO_IDX_MONO  = 16'h03B4;  // index port, mono decode
  localparam logic [15:0] IO_IDX_COLOR = 16'h03D4;  // index port, colour decode
  localparam logic [15:0] IO_DAT_MONO  = 16'h03B5;  // data port, mono decode
  localparam logic [15:0] IO_DAT_COLOR = 16'h03D5;  // data port, colour decode
  localparam logic [15:0] IO_STAT0     = 16'h03C2;  // input status zero, read only
  localparam logic [7:0] IX_PROT_LAST = 8'h07;  // last protected timing index
  localparam logic [7:0] IX_OVF       = 8'h07;  // timing_overflow_bits
  localparam logic [7:0] IX_SA_HI     = 8'h0C;  // start_address_high_byte
  localparam logic [7:0] IX_SA_LO     = 8'h0D;  // start_address_low_byte
  localparam logic [7:0] IX_CUR_HI    = 8'h0E;  // text_cursor_location_high
  localparam logic [7:0] IX_CUR_LO    = 8'h0F;  // text_cursor_location_low
  localparam logic [7:0] IX_VS_LO     = 8'h10;  // vertical_sync_start_low
  localparam logic [7:0] IX_VS_END    = 8'h11;  // vertical_sync_end_and_irq_ctl
  localparam logic [7:0] IX_EXT_VS    = 8'h32;  // extended_vertical_sync_start
  localparam logic [7:0] IX_EXT_SA    = 8'h40;  // extended_start_address
  localparam int SA_TRIG_BIT = 7;  // update trigger in low byte
  localparam int OVF_VS8_BIT = 2;  // sync start bit 8
  localparam int OVF_VS9_BIT = 7;  // sync start bit 9
  localparam int OVF_FREE_BIT = 4; // always writable overflow bit
  localparam int VE_PROT_BIT = 7;  // write protect
  localparam int VE_RSV_BIT  = 6;  // reserved, reads zero
  localparam int VE_IDIS_BIT = 5;  // 1 = interrupt disabled
  localparam int VE_ICLR_BIT = 4;  // 0 = hold interrupt cleared
  localparam int ST0_IRQ_BIT = 7;  // pending flag in status zero
  localparam logic [7:0]  RST_REG  = 8'h00;      // registers after reset
  localparam logic [19:0] RST_ADDR = 20'h0_0000; // start address after reset
  localparam logic [11:0] RST_LINE = 12'h000;    // line tracker after reset

  // io request from the host side
  typedef struct packed {
    logic [15:0] addr;  // io address
    logic        wr;    // write strobe
    logic        rd;    // read strobe
    logic [7:0]  wdata; // write data
  } crsv_io_t;

  // complete state of the block
  typedef struct packed {
    logic [7:0]  idx;      // index latch
    logic [7:0]  sa_lo;    // start address bits 7-0
    logic [7:0]  sa_hi;    // start address bits 15-8
    logic [7:0]  ext_sa;   // start address bits 19-16 in 3-0
    logic [7:0]  cur_hi;   // cursor bits 15-8
    logic [7:0]  cur_lo;   // cursor bits 7-0
    logic [7:0]  vs_lo;    // sync start bits 7-0
    logic [7:0]  vs_end;   // sync end and irq control
    logic [7:0]  ovf;      // overflow bits
    logic [7:0]  ext_vs;   // sync start bits 11-8 in 3-0
    logic        upd_pend; // start address update armed
    logic        irq;      // retrace interrupt pending
    logic        vsync;    // vertical sync output
    logic [11:0] line_prv; // last seen scan line
    logic [19:0] disp_sa;  // displayed start address
    logic [15:0] cursor;   // cursor offset output
    logic [7:0]  rdata;    // read data output
    logic        tw_stb;   // write to outer timing register
    logic [7:0]  tw_idx;   // its index
    logic [7:0]  tw_data;  // its data
  } crsv_state_t;
endpackage

/* rtl/crsv_top.sv */
// crt start address, cursor location, vertical sync and retrace flag registers
//
// How it works
// - standard mode start is high:low bytes
// - extended start adds four extended bits
// - extended start double buffered, changes at vsync
// - trigger bit arms load at next vsync
// - trigger bit self clears after load
// - cursor offset is high:low bytes
// - cursor ignored outside text modes
// - standard sync start uses overflow bits 7,2
// - extended sync start uses four extended bits
// - sync begins on line equal to start
// - sync end is four-bit value
// - protect bit blocks writes to indices 0-7
// - overflow bit four always writable
// - sync end bit six ignores writes
// - bit five zero enables retrace interrupt
// - no pin; status zero bit seven polled
// - bit four zero clears, must return to one
// - index then data port access
`timescale 1ns/1ns
module crsv_top
  import crsv_pkg::*;
(
  input  wire logic        clk_i,       // 50 MHz clock
  input  wire logic        rst_b_i,     // async reset, active low
  input  wire logic [15:0] io_addr_i,   // io address, same clock
  input  wire logic        io_wr_i,     // io write strobe
  input  wire logic        io_rd_i,     // io read strobe
  input  wire logic [7:0]  io_wdata_i,  // io write data
  input  wire logic        ext_mode_i,  // io_control_mode_select bit 0
  input  wire logic        text_mode_i, // 1 in text modes
  input  wire logic [11:0] line_i,      // scan line counter, 0 = first active
  output logic      [7:0]  io_rdata_o,  // read data, one cycle after io_rd_i
  output logic      [19:0] start_o,     // displayed start address
  output logic      [15:0] cursor_o,    // cursor offset, zero in graphics
  output logic             vsync_o,     // vertical sync, active high
  output logic             tw_stb_o,    // write pulse to outer timing reg
  output logic      [7:0]  tw_idx_o,    // its index
  output logic      [7:0]  tw_data_o    // its data
);

  crsv_state_t q;      // registered state
  crsv_state_t d;      // next state
  crsv_io_t    io;     // bundled request
  logic        dat_wr; // data port write
  logic        dat_rd; // data port read
  logic        idx_wr; // index port write
  logic [11:0] vs_start;  // selected sync start
  logic        new_line;  // scan line advanced
  logic        vs_begin;  // sync starts this cycle
  logic        vs_stop;   // sync ends this cycle
  logic        prot;      // writes to indices 0-7 blocked

  // port match, both decodes accepted
  function automatic logic port_is(input logic [15:0] a, input logic [15:0] m, input logic [15:0] c);
    port_is = (a == m) || (a == c);
  endfunction

  assign io = '{addr: io_addr_i, wr: io_wr_i, rd: io_rd_i, wdata: io_wdata_i};

  // host decode
  always_comb begin
    idx_wr = io.wr && port_is(io.addr, IO_IDX_MONO, IO_IDX_COLOR);
    dat_wr = io.wr && port_is(io.addr, IO_DAT_MONO, IO_DAT_COLOR);
    dat_rd = io.rd && port_is(io.addr, IO_DAT_MONO, IO_DAT_COLOR);
    prot   = q.vs_end[VE_PROT_BIT];
  end

  // sync timing from the shared line counter
  always_comb begin
    if (ext_mode_i) begin
      vs_start = {q.ext_vs[3:0], q.vs_lo};
    end else begin
      vs_start = {2'b00, q.ovf[OVF_VS9_BIT], q.ovf[OVF_VS8_BIT], q.vs_lo};
    end
    // edges come from a change of line so a held line fires once
    new_line = (line_i != q.line_prv);
    vs_begin = new_line && (line_i == vs_start);
    vs_stop  = q.vsync && new_line && !vs_begin
               && (line_i[3:0] == q.vs_end[3:0]);
  end

  // next state
  always_comb begin
    d = q;
    d.tw_stb   = 1'b0;
    d.line_prv = line_i;
    if (idx_wr) begin
      d.idx = io.wdata;
    end
    // register writes through the data port
    if (dat_wr) begin
      if (q.idx <= IX_PROT_LAST) begin
        if (q.idx == IX_OVF) begin
          // the free bit goes through even when protected
          d.ovf[OVF_FREE_BIT] = io.wdata[OVF_FREE_BIT];
          if (!prot) begin
            d.ovf = io.wdata;
          end
        end
        d.tw_stb  = !prot;
        d.tw_idx  = q.idx;
        d.tw_data = io.wdata;
      end
      unique case (q.idx)
        IX_SA_HI:  d.sa_hi  = io.wdata;
        IX_SA_LO: begin
          d.sa_lo = io.wdata;
          if (ext_mode_i && io.wdata[SA_TRIG_BIT]) begin
            d.upd_pend = 1'b1;
          end
        end
        IX_CUR_HI: d.cur_hi = io.wdata;
        IX_CUR_LO: d.cur_lo = io.wdata;
        IX_VS_LO:  d.vs_lo  = io.wdata;
        IX_VS_END: begin
          d.vs_end = io.wdata;
          d.vs_end[VE_RSV_BIT] = 1'b0;
        end
        IX_EXT_VS: d.ext_vs = {4'h0, io.wdata[3:0]};
        IX_EXT_SA: d.ext_sa = {4'h0, io.wdata[3:0]};
        default: begin
        end
      endcase
    end
    // displayed start address
    if (!ext_mode_i) begin
      d.disp_sa  = {4'h0, q.sa_hi, q.sa_lo};
      d.upd_pend = 1'b0;
    end else if (vs_begin && q.upd_pend) begin
      // only at vsync, so a half written address never shows
      d.disp_sa  = {q.ext_sa[3:0], q.sa_hi, q.sa_lo};
      // the load consumes the trigger; only a trigger written in this very
      // cycle stays armed, so a plain low byte write cannot re-arm it
      d.upd_pend = dat_wr && (q.idx == IX_SA_LO) && io.wdata[SA_TRIG_BIT];
    end
    // sync pulse
    if (vs_begin) begin
      d.vsync = 1'b1;
    end else if (vs_stop) begin
      d.vsync = 1'b0;
    end
    // retrace flag; the clear bit is a level that holds it off
    if (!q.vs_end[VE_ICLR_BIT]) begin
      d.irq = 1'b0;
    end else if (vs_begin && !q.vs_end[VE_IDIS_BIT]) begin
      d.irq = 1'b1;
    end
    // cursor is meaningless in graphics, so it is forced off there
    d.cursor = text_mode_i ? {q.cur_hi, q.cur_lo} : 16'h0000;
    // read data
    if (io.rd && (io.addr == IO_STAT0)) begin
      d.rdata = 8'h00;
      d.rdata[ST0_IRQ_BIT] = q.irq;
    end else if (dat_rd) begin
      unique case (q.idx)
        IX_OVF:    d.rdata = q.ovf;
        IX_SA_HI:  d.rdata = q.sa_hi;
        IX_SA_LO: begin
          d.rdata = q.sa_lo;
          if (ext_mode_i) begin
            d.rdata[SA_TRIG_BIT] = q.upd_pend;
          end
        end
        IX_CUR_HI: d.rdata = q.cur_hi;
        IX_CUR_LO: d.rdata = q.cur_lo;
        IX_VS_LO:  d.rdata = q.vs_lo;
        IX_VS_END: d.rdata = q.vs_end;
        IX_EXT_VS: d.rdata = q.ext_vs;
        IX_EXT_SA: d.rdata = q.ext_sa;
        default:   d.rdata = 8'h00;
      endcase
    end else if (io.rd && (io.addr == IO_IDX_MONO || io.addr == IO_IDX_COLOR)) begin
      d.rdata = q.idx;
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= '{idx: RST_REG, sa_lo: RST_REG, sa_hi: RST_REG, ext_sa: RST_REG,
             cur_hi: RST_REG, cur_lo: RST_REG, vs_lo: RST_REG, vs_end: RST_REG,
             ovf: RST_REG, ext_vs: RST_REG, upd_pend: 1'b0, irq: 1'b0,
             vsync: 1'b0, line_prv: RST_LINE, disp_sa: RST_ADDR,
             cursor: 16'h0000, rdata: RST_REG, tw_stb: 1'b0,
             tw_idx: RST_REG, tw_data: RST_REG};
    end else begin
      q <= d;
    end
  end

  assign io_rdata_o = q.rdata;
  assign start_o    = q.disp_sa;
  assign cursor_o   = q.cursor;
  assign vsync_o    = q.vsync;
  assign tw_stb_o   = q.tw_stb;
  assign tw_idx_o   = q.tw_idx;
  assign tw_data_o  = q.tw_data;

  // all checks share the one clock; reset switches them off
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  std_start_a: assert property (!ext_mode_i |=> start_o == {4'h0, $past(q.sa_hi), $past(q.sa_lo)})
    else $error("standard start address wrong");
  ext_hold_a: assert property (ext_mode_i && !vs_begin && $past(ext_mode_i) |=> $stable(start_o))
    else $error("extended start changed outside vsync");
  ext_load_a: assert property (ext_mode_i && vs_begin && q.upd_pend
                               |=> start_o == {$past(q.ext_sa[3:0]), $past(q.sa_hi), $past(q.sa_lo)})
    else $error("extended start not loaded at vsync");
  trig_clr_a: assert property (ext_mode_i && vs_begin && q.upd_pend && !dat_wr |=> !q.upd_pend)
    else $error("update trigger not cleared");
  arm_a: assert property (ext_mode_i && dat_wr && q.idx == IX_SA_LO && io_wdata_i[7] |=> q.upd_pend)
    else $error("update trigger not armed");
  cursor_a: assert property (##1 cursor_o == ($past(text_mode_i)
                             ? {$past(q.cur_hi), $past(q.cur_lo)} : 16'h0000))
    else $error("cursor output wrong");
  vs_begin_a: assert property (vs_begin |=> vsync_o ##1 (vsync_o || $past(vs_stop)))
    else $error("vsync did not start");
  vs_end_a: assert property (vs_stop |=> !vsync_o)
    else $error("vsync did not end");
  prot_a: assert property (dat_wr && prot && q.idx <= IX_PROT_LAST |=> !tw_stb_o && $stable(q.ovf[3:0]))
    else $error("protected write took effect");
  ovf_free_a: assert property (dat_wr && q.idx == IX_OVF |=> q.ovf[4] == $past(io_wdata_i[4]))
    else $error("overflow bit four not written");
  rsv_bit_a: assert property (dat_wr && q.idx == IX_VS_END |=> !q.vs_end[6])
    else $error("reserved bit stored");
  irq_hold_a: assert property (!q.vs_end[VE_ICLR_BIT] |=> !q.irq ##1 (q.irq -> $past(q.vs_end[4])))
    else $error("interrupt not held cleared");
  irq_set_a: assert property (vs_begin && q.vs_end[5:4] == 2'b01 |=> q.irq)
    else $error("interrupt not raised");
  irq_off_a: assert property (!q.irq && q.vs_end[5] |=> !q.irq)
    else $error("disabled interrupt raised");
  stat_a: assert property (io_rd_i && io_addr_i == IO_STAT0 |=> io_rdata_o[7] == $past(q.irq))
    else $error("status zero bit wrong");

  // an index port write is latched as the register pointer
  idx_latch_a: assert property (idx_wr |=> q.idx == $past(io_wdata_i))
    else $error("index not latched");

  // reading the index port hands back the latched pointer
  idx_read_a: assert property (io_rd_i && port_is(io_addr_i, IO_IDX_MONO, IO_IDX_COLOR)
                               |=> io_rdata_o == $past(q.idx))
    else $error("index read wrong");

  // data port reads of sync start come back unchanged
  vs_read_a: assert property (dat_rd && q.idx == IX_VS_LO |=> io_rdata_o == $past(q.vs_lo))
    else $error("sync start read wrong");

  // reserved bit always reads back as zero
  rsv_read_a: assert property (dat_rd && q.idx == IX_VS_END |=> !io_rdata_o[VE_RSV_BIT])
    else $error("reserved bit read as one");

  // low start byte is stored as written, trigger bit included
  sa_store_a: assert property (dat_wr && q.idx == IX_SA_LO |=> q.sa_lo == $past(io_wdata_i))
    else $error("start low byte not stored");

  // extended start keeps only its low nibble
  ext_nib_a: assert property (dat_wr && q.idx == IX_EXT_SA |=> q.ext_sa == {4'h0, $past(io_wdata_i[3:0])})
    else $error("extended start nibble wrong");

  // no update may stay armed in standard mode
  std_arm_a: assert property (!ext_mode_i |=> !q.upd_pend)
    else $error("trigger armed in standard mode");

  // cursor low byte is stored as written
  cur_store_a: assert property (dat_wr && q.idx == IX_CUR_LO |=> q.cur_lo == $past(io_wdata_i))
    else $error("cursor low byte not stored");

  // graphics mode shows no cursor
  cur_off_a: assert property (!text_mode_i |=> cursor_o == 16'h0000)
    else $error("cursor shown in graphics");

  // standard sync begins where overflow bits 7 and 2 point
  std_sync_a: assert property (vs_begin && !ext_mode_i
                               |-> line_i == {2'b00, q.ovf[OVF_VS9_BIT], q.ovf[OVF_VS8_BIT], q.vs_lo})
    else $error("standard sync start wrong");

  // extended sync begins where the extended nibble points
  ext_sync_a: assert property (vs_begin && ext_mode_i |-> line_i == {q.ext_vs[3:0], q.vs_lo})
    else $error("extended sync start wrong");

  // sync only rises on a start line
  sync_rise_a: assert property ($rose(vsync_o) |-> $past(vs_begin))
    else $error("sync rose off start line");

  // sync only falls on a matching end line
  sync_fall_a: assert property ($fell(vsync_o) |-> $past(vs_stop))
    else $error("sync fell off end line");

  // a permitted timing write is passed on with index and data
  tw_fwd_a: assert property (dat_wr && !prot && q.idx <= IX_PROT_LAST
                             |=> tw_stb_o && tw_idx_o == $past(q.idx) && tw_data_o == $past(io_wdata_i))
    else $error("timing write not forwarded");

  // a protected overflow write moves only the free bit
  ovf_lock_a: assert property (dat_wr && prot && q.idx == IX_OVF
                               |=> $stable(q.ovf[7:5]) && $stable(q.ovf[3:0]))
    else $error("protected overflow bits changed");

  // the retrace flag only rises on a sync start line
  irq_rise_a: assert property ($rose(q.irq) |-> $past(vs_begin))
    else $error("retrace flag rose off sync start");
endmodule

/* bench/crsv_host.sv */
// host model: io index/data port master for the register block
`timescale 1ns/1ns
module crsv_host
  import crsv_pkg::*;
(
  input  wire logic        clk_i,   // bench clock
  input  wire logic [7:0]  rdata_i, // read data from block
  output logic      [15:0] addr_o,  // io address
  output logic             wr_o,    // write strobe
  output logic             rd_o,    // read strobe
  output logic      [7:0]  wdata_o  // write data
);
  initial begin
    addr_o  = 16'h0000;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    wdata_o = 8'h00;
  end
  // one write; strobe drops a full edge before the next request may rise
  task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    wdata_o <= ~d; // released data must not look like a valid byte
  endtask
  // one read; data is taken an edge after the strobe was sampled
  task automatic io_rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clk_i);
    rd_o   <= 1'b0;
    @(posedge clk_i);
    d = rdata_i;
  endtask
  // index first, then data; both decodes are exercised
  task automatic reg_wr(input logic [7:0] ix, input logic [7:0] d);
    io_wr(IO_IDX_COLOR, ix);
    io_wr(IO_DAT_MONO, d);
  endtask
  task automatic reg_rd(input logic [7:0] ix, output logic [7:0] d);
    io_wr(IO_IDX_MONO, ix);
    io_rd(IO_DAT_COLOR, d);
  endtask
endmodule

/* bench/crsv_top_tb_top.sv */
// self-checking bench for the crt start, cursor, sync and retrace registers
`timescale 1ns/1ns
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin failures++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); end end
module crsv_top_tb_top;
  import crsv_pkg::*;
  logic        clk_i, rst_b_i, ext_mode_i, text_mode_i, io_wr, io_rd, vsync_o, tw_stb;
  logic [15:0] io_addr, cursor_o;
  logic [7:0]  io_wdata, io_rdata, tw_idx_o, tw_data_o, tw_cnt;
  logic [11:0] line_i;
  logic [19:0] start_o;
  int          failures, n_checks;
  crsv_host host (.clk_i(clk_i), .rdata_i(io_rdata), .addr_o(io_addr), .wr_o(io_wr), .rd_o(io_rd),
                  .wdata_o(io_wdata));
  crsv_top DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .io_addr_i(io_addr), .io_wr_i(io_wr), .io_rd_i(io_rd),
                .io_wdata_i(io_wdata), .ext_mode_i(ext_mode_i), .text_mode_i(text_mode_i), .line_i(line_i),
                .io_rdata_o(io_rdata), .start_o(start_o), .cursor_o(cursor_o), .vsync_o(vsync_o),
                .tw_stb_o(tw_stb), .tw_idx_o(tw_idx_o), .tw_data_o(tw_data_o));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // counts forwarded timing writes so a refused write shows as no change
  always @(posedge clk_i) begin
    if (!rst_b_i) tw_cnt <= 8'h00;
    else if (tw_stb === 1'b1) tw_cnt <= tw_cnt + 8'd1;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // walks the line counter; sync must be high only from rise up to fall
  task automatic step_lines(input logic [11:0] lo, hi, rise, fall);
    for (logic [11:0] l = lo; l <= hi; l++) begin
      line_i <= l;
      repeat (2) @(posedge clk_i);
      `CHK(vsync_o, (l >= rise && l < fall))
    end
  endtask
  task automatic t_cursor();
    logic [7:0] d;
    host.reg_wr(IX_CUR_HI, 8'h12);
    host.reg_wr(IX_CUR_LO, 8'h34);
    repeat (2) @(posedge clk_i);
    `CHK(cursor_o, 16'h1234)
    host.reg_rd(IX_CUR_HI, d);
    `CHK(d, 8'h12)
    host.reg_rd(8'h20, d);
    `CHK(d, 8'h00)
    @(posedge clk_i);
    text_mode_i <= 1'b0; // graphics mode hides the cursor
    repeat (2) @(posedge clk_i);
    `CHK(cursor_o, 16'h0000)
    $display("t_cursor done");
  endtask
  task automatic t_start();
    logic [7:0] d;
    host.reg_wr(IX_SA_HI, 8'hAB);
    host.reg_wr(IX_SA_LO, 8'hCD);
    repeat (2) @(posedge clk_i);
    `CHK(start_o, 20'h0_ABCD)
    @(posedge clk_i);
    ext_mode_i <= 1'b1;
    host.reg_wr(IX_EXT_SA, 8'h05);
    host.reg_wr(IX_SA_HI, 8'h11);
    host.reg_wr(IX_EXT_VS, 8'h01);
    host.reg_wr(IX_VS_LO, 8'h20);
    host.reg_wr(IX_VS_END, 8'h13);
    host.reg_wr(IX_SA_LO, 8'hA2);
    repeat (4) @(posedge clk_i);
    `CHK(start_o, 20'h0_ABCD)
    step_lines(12'h11E, 12'h124, 12'h120, 12'h123);
    `CHK(start_o, 20'h5_11A2)
    host.reg_rd(IX_SA_LO, d);
    `CHK(d, 8'h22)
    host.io_rd(IO_STAT0, d);
    `CHK(d[ST0_IRQ_BIT], 1'b1)
    $display("t_start done");
  endtask
  task automatic t_irq();
    logic [7:0] d;
    host.reg_wr(IX_VS_END, 8'h03);
    host.io_rd(IO_STAT0, d);
    `CHK(d[ST0_IRQ_BIT], 1'b0)
    step_lines(12'h11E, 12'h124, 12'h120, 12'h123);
    host.io_rd(IO_STAT0, d);
    `CHK(d[ST0_IRQ_BIT], 1'b0)
    host.reg_wr(IX_VS_END, 8'h33);
    step_lines(12'h11E, 12'h124, 12'h120, 12'h123);
    host.io_rd(IO_STAT0, d);
    `CHK(d[ST0_IRQ_BIT], 1'b0)
    host.reg_wr(IX_VS_END, 8'h13);
    step_lines(12'h11E, 12'h124, 12'h120, 12'h123);
    host.io_rd(IO_STAT0, d);
    `CHK(d[ST0_IRQ_BIT], 1'b1)
    $display("t_irq done");
  endtask
  task automatic t_protect();
    logic [7:0] d, n;
    host.reg_wr(IX_VS_END, 8'hD3);
    host.reg_rd(IX_VS_END, d);
    `CHK(d, 8'h93)
    n = tw_cnt;
    host.reg_wr(IX_OVF, 8'hFF);
    host.reg_wr(8'h02, 8'h5A);
    repeat (2) @(posedge clk_i);
    `CHK(tw_cnt, n)
    host.reg_rd(IX_OVF, d);
    `CHK(d, 8'h10)
    host.reg_wr(IX_VS_END, 8'h18);
    host.reg_wr(8'h02, 8'h5A);
    repeat (2) @(posedge clk_i);
    `CHK(tw_cnt, n + 8'd1)
    `CHK({tw_idx_o, tw_data_o}, 16'h025A)
    @(posedge clk_i);
    ext_mode_i <= 1'b0; // standard mode takes the top sync bits from overflow
    host.reg_wr(IX_OVF, 8'h80);
    host.reg_wr(IX_VS_LO, 8'h05);
    step_lines(12'h203, 12'h209, 12'h205, 12'h208);
    $display("t_protect done");
  endtask
  initial begin
    rst_b_i     = 1'b0;
    ext_mode_i  = 1'b0;
    text_mode_i = 1'b1;
    line_i      = 12'h000;
    failures    = 0;
    n_checks    = 0;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_cursor();
    t_start();
    t_irq();
    t_protect();
    finish_test();
  end
  // a hang is cut short and counted as a mismatch
  initial begin
    #1_000_000;
    failures++;
    finish_test();
  end
endmodule
